/* File: common/spfa_consts.svh */
// constants for the secure priority field access block
`ifndef SPFA_CONSTS_SVH
`define SPFA_CONSTS_SVH
`define SPFA_PRIO_W 8
`define SPFA_NUM_INT 32
`define SPFA_IDX_W 5
`define SPFA_IMPL_BITS 5
`define SPFA_MIN_IMPL 5
`define SPFA_MAX_IMPL 8
`define SPFA_TOP_BIT 7
`define SPFA_PRIO_RST 8'h00
`define SPFA_PMR_RST 8'h00
`define SPFA_RPR_IDLE 8'hff
`define SPFA_ALL_ONES 8'hff
`endif

/* File: common/spfa_if.sv */
// request and answer wires between an issuing element and the priority block
`timescale 1ns/1ps
interface spfa_if;
  logic req_valid;
  logic req_ready;
  logic req_write;
  logic req_secure;
  spfa_pkg::spfa_target_t req_target;
  logic [4:0] req_index;
  logic [7:0] req_wdata;
  logic rsp_valid;
  logic [7:0] rsp_rdata;
  modport device
  (
    input req_valid,
    output req_ready,
    input req_write,
    input req_secure,
    input req_target,
    input req_index,
    input req_wdata,
    output rsp_valid,
    output rsp_rdata
  );
  modport requester
  (
    output req_valid,
    input req_ready,
    output req_write,
    output req_secure,
    output req_target,
    output req_index,
    output req_wdata,
    input rsp_valid,
    input rsp_rdata
  );
endinterface

/* File: common/spfa_pkg.sv */
// types for the secure priority field access block
package spfa_pkg;
  typedef enum logic [1:0]
  {
    SPFA_TGT_FIELD = 2'b00,
    SPFA_TGT_PMR = 2'b01,
    SPFA_TGT_RPR = 2'b11
  } spfa_target_t;
  typedef enum logic [1:0]
  {
    SPFA_GRP0 = 2'b00,
    SPFA_GRP1_S = 2'b01,
    SPFA_GRP1_NS = 2'b11
  } spfa_group_t;
endpackage

/* File: logic/spfa_device.sv */
// priority storage and secure/non-secure access translation
`timescale 1ns/1ps
`include "spfa_consts.svh"

// Overview of operation
// R1: non-secure group 1 reads depend on security
// R2: five to eight high priority bits stored
// R3: secure sees all; unimplemented low bits zero
// R4: secure read returns stored value unchanged
// R5: non-secure sees half the levels, min 16
// R6: non-secure view bit zero reads zero
// R7: non-secure write shifts right, sets bit 7
// R8: secure write may clear bit 7 untranslated
// R9: stored bit7 clear: non-secure reads shifted left
// R10: non-secure write always leaves bit 7 set
// R11: non-secure step follows implemented width
// R12: mask below half: non-secure raz/wi
// R13: running below half: non-secure reads zero
// R14: software keeps group 0 in upper half
// R15: software allocation example by top bits
// R16: writing all ones reads back implemented bits
// R17: software quiesces interrupt before probing
// R18: priority rewrite applies next cycle, no loss
// R19: single security state sees fields directly
module spfa_device
#(
  parameter int IMPL_BITS = `SPFA_IMPL_BITS,
  parameter bit TWO_STATES = 1'b1
)
(
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // access port
  spfa_if.device bus,
  // interrupt attributes and state
  input wire logic [`SPFA_NUM_INT*2-1:0] group_in,
  input wire logic [`SPFA_PRIO_W-1:0] running_prio_in,
  input wire logic [`SPFA_IDX_W-1:0] query_index_in,
  output logic [`SPFA_PRIO_W-1:0] query_prio_out,
  output logic [`SPFA_PRIO_W-1:0] mask_prio_out
);
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // ones on the implemented high-order bits
  function automatic logic [7:0] impl_mask();
    logic [7:0] m;
    m = `SPFA_ALL_ONES;
    for (int i = 0; i < 8; i++)
    begin
      if (i < 8 - IMPL_BITS)
      begin
        m[i] = 1'b0;
      end
    end
    return m;
  endfunction

  // non-secure view of a stored value; unimplemented bits already zero
  function automatic logic [7:0] ns_view(input logic [7:0] v);
    return {v[6:0], 1'b0}; // [R6] [R9] [R11] [R5]
  endfunction

  // translate a non-secure write into the stored form
  function automatic logic [7:0] ns_store(input logic [7:0] v);
    return {1'b1, v[7:1]} & impl_mask(); // [R7] [R10] [R3]
  endfunction

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  logic [7:0] prio_r [`SPFA_NUM_INT];
  logic [7:0] pmr_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  spfa_pkg::spfa_group_t grp;
  logic ns_mode;
  logic take;

  // parameter above 8 acts as 8 in the mask arithmetic; below 5 is neither checked nor clamped
  assign ns_mode = TWO_STATES && !bus.req_secure; // [R19]
  assign take = bus.req_valid && bus.req_ready;
  assign bus.req_ready = 1'b1;
  assign grp = spfa_pkg::spfa_group_t'(group_in[bus.req_index*2 +: 2]);

  // --------------------------------------------------------------
  // priority field writes
  // --------------------------------------------------------------
  // a new value is used from the next cycle; nothing else is dropped [R18]
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int i = 0; i < `SPFA_NUM_INT; i++)
      begin
        prio_r[i] <= `SPFA_PRIO_RST;
      end
    end
    else if (take && bus.req_write
             && bus.req_target == spfa_pkg::SPFA_TGT_FIELD)
    begin
      if (!ns_mode)
      begin
        prio_r[bus.req_index] <= bus.req_wdata & impl_mask(); // [R2] [R8] [R16]
      end
      else if (grp == spfa_pkg::SPFA_GRP1_NS)
      begin
        prio_r[bus.req_index] <= ns_store(bus.req_wdata); // [R7]
      end
      // secure-group fields ignore non-secure writes
    end
  end

  // --------------------------------------------------------------
  // priority mask writes
  // --------------------------------------------------------------
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pmr_r <= `SPFA_PMR_RST;
    end
    else if (take && bus.req_write
             && bus.req_target == spfa_pkg::SPFA_TGT_PMR)
    begin
      if (!ns_mode)
      begin
        pmr_r <= bus.req_wdata & impl_mask(); // [R3]
      end
      else if (pmr_r[`SPFA_TOP_BIT])
      begin
        pmr_r <= ns_store(bus.req_wdata); // [R12]
      end
    end
  end

  // --------------------------------------------------------------
  // read answers
  // --------------------------------------------------------------
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rdata_r <= `SPFA_PRIO_RST;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= take && !bus.req_write;
      if (take && !bus.req_write)
      begin
        unique case (bus.req_target)
          spfa_pkg::SPFA_TGT_FIELD:
          begin
            if (!ns_mode)
            begin
              rdata_r <= prio_r[bus.req_index]; // [R4] [R1]
            end
            else if (grp == spfa_pkg::SPFA_GRP1_NS)
            begin
              rdata_r <= ns_view(prio_r[bus.req_index]); // [R1] [R9]
            end
            else
            begin
              rdata_r <= `SPFA_PRIO_RST;
            end
          end
          spfa_pkg::SPFA_TGT_PMR:
          begin
            if (!ns_mode)
            begin
              rdata_r <= pmr_r;
            end
            else
            begin
              rdata_r <= pmr_r[`SPFA_TOP_BIT] ? ns_view(pmr_r)
                         : `SPFA_PRIO_RST; // [R12]
            end
          end
          spfa_pkg::SPFA_TGT_RPR:
          begin
            if (!ns_mode)
            begin
              rdata_r <= running_prio_in & impl_mask();
            end
            else
            begin
              rdata_r <= running_prio_in[`SPFA_TOP_BIT]
                         ? ns_view(running_prio_in & impl_mask())
                         : `SPFA_PRIO_RST; // [R13]
            end
          end
          default:
          begin
            rdata_r <= `SPFA_PRIO_RST;
          end
        endcase
      end
    end
  end

  assign bus.rsp_valid = rvalid_r;
  assign bus.rsp_rdata = rdata_r;
  // full stored priority feeds the prioritiser, registered storage
  assign query_prio_out = prio_r[query_index_in];
  assign mask_prio_out = pmr_r;
endmodule

/* File: logic/spfa_requester.sv */
// issuing element end: commands passed through back to back, answer captured
`timescale 1ns/1ps
`include "spfa_consts.svh"
module spfa_requester
(
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // access port
  spfa_if.requester bus,
  // user command side
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic cmd_write_in,
  input wire logic cmd_secure_in,
  input wire spfa_pkg::spfa_target_t cmd_target_in,
  input wire logic [`SPFA_IDX_W-1:0] cmd_index_in,
  input wire logic [`SPFA_PRIO_W-1:0] cmd_wdata_in,
  output logic rsp_valid_out,
  output logic [`SPFA_PRIO_W-1:0] rsp_rdata_out
);
  // ------------------------------------------------------------
  // request pass-through and answer capture
  // ------------------------------------------------------------
  // R14, R15 and R17 are software policy; this end only carries the access
  logic [7:0] rdata_r;
  logic rvalid_r;

  assign bus.req_valid = cmd_valid_in;
  assign cmd_ready_out = bus.req_ready;
  assign bus.req_write = cmd_write_in;
  assign bus.req_secure = cmd_secure_in;
  assign bus.req_target = cmd_target_in;
  assign bus.req_index = cmd_index_in;
  assign bus.req_wdata = cmd_wdata_in;

  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rdata_r <= `SPFA_PRIO_RST;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= bus.rsp_valid;
      if (bus.rsp_valid)
      begin
        rdata_r <= bus.rsp_rdata; // [R16]
      end
    end
  end

  assign rsp_valid_out = rvalid_r;
  assign rsp_rdata_out = rdata_r;
endmodule

/* File: verif/spfa_properties.sv */
// assertions on the wires between requester and device
`timescale 1ns/1ps
module spfa_properties
#(
  parameter int IMPL_BITS = 5
)
(
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // watched wires
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_secure,
  input wire spfa_pkg::spfa_target_t req_target,
  input wire logic [4:0] req_index,
  input wire logic [7:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_rdata
);
  localparam logic [7:0] s_mask = 8'hff << (8 - IMPL_BITS);
  localparam logic [7:0] ns_mask = 8'hff << (9 - IMPL_BITS);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);
  sequence s_take(w, s);
    req_valid && req_write == w && req_secure == s &&
      req_target == spfa_pkg::SPFA_TGT_FIELD;
  endsequence
  // secure write then a read of the same field on the next edge
  sequence s_wr_rd(s);
    s_take(1'b1, 1'b1) ##1 s_take(1'b0, s) ##0 req_index == $past(req_index);
  endsequence
  a_read_answer:
    assert property (req_valid && !req_write |=> rsp_valid)
    else $error("read not answered");
  a_write_quiet:
    assert property (!(req_valid && !req_write) |=> !rsp_valid)
    else $error("answer without read");
  a_ns_even:
    assert property (rsp_valid && !$past(req_secure) |-> !rsp_rdata[0])
    else $error("odd non-secure value");
  a_ns_step:
    assert property (rsp_valid && !$past(req_secure) |->
      (rsp_rdata & ~ns_mask) == 8'h00)
    else $error("non-secure step wrong");
  a_impl_bits:
    assert property (rsp_valid |-> (rsp_rdata & ~s_mask) == 8'h00)
    else $error("unimplemented bits set");
  a_rdata_holds:
    assert property (!rsp_valid |-> $stable(rsp_rdata))
    else $error("read data moved");
  a_sec_view:
    assert property (s_wr_rd(1'b1) |=>
      rsp_rdata == ($past(req_wdata, 2) & s_mask))
    else $error("secure view wrong");
  a_ns_view:
    assert property (s_wr_rd(1'b0) |=> rsp_rdata == 8'h00 ||
      rsp_rdata == (($past(req_wdata, 2) << 1) & ns_mask))
    else $error("non-secure view wrong");
endmodule

/* File: verif/tb.sv */
// self-checking bench: requester end against device end
`timescale 1ns/1ps
module tb;
  localparam spfa_pkg::spfa_target_t fld = spfa_pkg::SPFA_TGT_FIELD;
  localparam spfa_pkg::spfa_target_t pmr = spfa_pkg::SPFA_TGT_PMR;
  localparam spfa_pkg::spfa_target_t rpr = spfa_pkg::SPFA_TGT_RPR;
  logic clock_in, arst_n_in, cmd_valid, cmd_write, cmd_secure, rsp_valid;
  spfa_pkg::spfa_target_t cmd_target;
  logic [4:0] cmd_index;
  logic [7:0] cmd_wdata, running_prio, query_prio, mask_prio, rdata;
  int err_count, tests_run;
  spfa_if bus_if();
  logic rsp_valid1, cmd_ready, cmd_ready1;
  logic [7:0] rdata1, query1, mask1;
  spfa_if bus1_if();
  spfa_requester spfa_requester_i
  (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .bus(bus_if),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready),
    .cmd_write_in(cmd_write),
    .cmd_secure_in(cmd_secure), .cmd_target_in(cmd_target),
    .cmd_index_in(cmd_index), .cmd_wdata_in(cmd_wdata),
    .rsp_valid_out(rsp_valid), .rsp_rdata_out(rdata)
  );
  // index 0 group 0, 1 secure group 1, 2 non-secure group 1
  spfa_device #(.IMPL_BITS(5), .TWO_STATES(1'b1)) spfa_device_i
  (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .bus(bus_if),
    .group_in(64'h0000_0000_0000_0034), .running_prio_in(running_prio),
    .query_index_in(5'h02), .query_prio_out(query_prio),
    .mask_prio_out(mask_prio)
  );
  // same commands into a single-state pair: no translation anywhere
  spfa_requester spfa_requester_one_i
  (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .bus(bus1_if),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready1),
    .cmd_write_in(cmd_write), .cmd_secure_in(cmd_secure),
    .cmd_target_in(cmd_target), .cmd_index_in(cmd_index),
    .cmd_wdata_in(cmd_wdata), .rsp_valid_out(rsp_valid1),
    .rsp_rdata_out(rdata1)
  );
  spfa_device #(.IMPL_BITS(5), .TWO_STATES(1'b0)) spfa_device_one_i
  (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .bus(bus1_if),
    .group_in(64'h0000_0000_0000_0034), .running_prio_in(running_prio),
    .query_index_in(5'h02), .query_prio_out(query1),
    .mask_prio_out(mask1)
  );
  spfa_properties #(.IMPL_BITS(5)) spfa_properties_i
  (
    .clock_in(clock_in), .arst_n_in(arst_n_in),
    .req_valid(bus_if.req_valid), .req_write(bus_if.req_write),
    .req_secure(bus_if.req_secure), .req_target(bus_if.req_target),
    .req_index(bus_if.req_index), .req_wdata(bus_if.req_wdata),
    .rsp_valid(bus_if.rsp_valid), .rsp_rdata(bus_if.rsp_rdata)
  );
  initial
  begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  task automatic chk(input string n, input logic [7:0] e, a);
    tests_run++;
    if (a !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, a);
    end
  endtask
  // request stays up so a following call is taken back to back
  task automatic acc(input logic w, s, input spfa_pkg::spfa_target_t t,
    input logic [4:0] i, input logic [7:0] d);
    @(posedge clock_in);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_secure <= s;
    cmd_target <= t;
    cmd_index <= i;
    cmd_wdata <= d;
  endtask
  task automatic rd(input logic s, input spfa_pkg::spfa_target_t t,
    input logic [4:0] i, input logic [7:0] e);
    int n;
    acc(1'b0, s, t, i, 8'h00);
    @(posedge clock_in);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clock_in);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 8);
    chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
    chk("rsp_rdata", e, rdata);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // whole run is some 60 cycles; cut off well beyond
  initial
  begin
    #100000;
    err_count++;
    conclude();
  end
  initial
  begin
    {arst_n_in, cmd_valid, cmd_write, cmd_secure} = 4'h0;
    cmd_target = fld;
    {cmd_index, cmd_wdata} = {5'h00, 8'h00};
    running_prio = 8'h40;
    err_count = 0;
    tests_run = 0;
    repeat (8) @(posedge clock_in);
    arst_n_in <= 1'b1;
    rd(1'b1, fld, 5'h02, 8'h00);
    chk("mask_prio", 8'h00, mask_prio);
    acc(1'b1, 1'b1, fld, 5'h02, 8'hff);
    rd(1'b1, fld, 5'h02, 8'hf8);
    rd(1'b0, fld, 5'h02, 8'hf0);
    acc(1'b1, 1'b0, fld, 5'h02, 8'h00);
    rd(1'b1, fld, 5'h02, 8'h80);
    acc(1'b1, 1'b1, fld, 5'h02, 8'h35);
    rd(1'b0, fld, 5'h02, 8'h60);
    chk("query_prio", 8'h30, query_prio);
    acc(1'b1, 1'b0, fld, 5'h02, 8'h10);
    rd(1'b1, fld, 5'h02, 8'h88);
    acc(1'b1, 1'b1, fld, 5'h00, 8'h28);
    acc(1'b1, 1'b0, fld, 5'h00, 8'h40);
    rd(1'b1, fld, 5'h00, 8'h28);
    acc(1'b1, 1'b1, fld, 5'h01, 8'h48);
    rd(1'b0, fld, 5'h01, 8'h00);
    acc(1'b1, 1'b1, pmr, 5'h00, 8'h40);
    acc(1'b1, 1'b0, pmr, 5'h00, 8'hff);
    rd(1'b0, pmr, 5'h00, 8'h00);
    chk("mask_prio", 8'h40, mask_prio);
    acc(1'b1, 1'b1, pmr, 5'h00, 8'ha0);
    acc(1'b1, 1'b0, pmr, 5'h00, 8'h20);
    rd(1'b1, pmr, 5'h00, 8'h90);
    rd(1'b0, rpr, 5'h00, 8'h00);
    @(posedge clock_in);
    running_prio <= 8'hc0;
    rd(1'b0, rpr, 5'h00, 8'h80);
    acc(1'b1, 1'b0, fld, 5'h02, 8'h88);
    rd(1'b0, fld, 5'h02, 8'h80);
    chk("rsp_valid_single", 8'h01, {7'h00, rsp_valid1});
    chk("rdata_single", 8'h88, rdata1);
    chk("query_single", 8'h88, query1);
    chk("mask_single", 8'h20, mask1);
    chk("cmd_ready", 8'h01, {7'h00, cmd_ready});
    chk("cmd_ready_single", 8'h01, {7'h00, cmd_ready1});
    conclude();
  end
endmodule
